/* hdl/armd_device.sv */
// Function
// RQ1 - multiple read interrupts once per block
// RQ2 - drq set only at block start
// RQ3 - sector count means total sectors requested
// RQ4 - count below block size still executes
// RQ5 - host never issues multiple read with zero
// RQ6 - full blocks first, then remainder block
// RQ7 - multiple read without block size aborts
// RQ8 - error stops; registers show failing sector
// RQ9 - interrupt together with drq per block
// RQ10 - host sets block size before multiple read
// RQ11 - count zero on success, remaining on error
// RQ12 - dma read moves data under dmarq
// RQ13 - device alone drives dmarq
// RQ14 - dma read posts status once at end
// RQ15 - dma error stops, interrupts, posts status
// RQ16 - lba mode start and end addresses
// RQ17 - features 03, count 22 selects mw2
// RQ18 - features 03, count 42 selects udma2
// RQ19 - lba packs head nibble, cylinder, sector
// RQ20 - count zero means 256 sectors
// RQ21 - dh bit 6 lba, bit 4 drive
`timescale 1ns/10ps
`include "armd_regs.svh"

module armd_device
  import armd_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  armd_if.dev bus,
  output logic [27:0] med_addr,
  output logic med_lba_mode,
  output logic [7:0] med_idx,
  input wire logic [15:0] med_word,
  input wire logic med_err,
  output logic busy,
  output armd_dma_mode_e dma_mode
);

  armd_dev_state_e state_q, state_d;
  logic [7:0] fr_q, fr_d, err_q, err_d, sc_q, sc_d, sn_q, sn_d;
  logic [7:0] cl_q, cl_d, ch_q, ch_d, dh_q, dh_d;
  logic bsy_q, bsy_d, drq_q, drq_d, errst_q, errst_d, intrq_q, intrq_d;
  logic [7:0] mult_q, mult_d, blk_q, blk_d, idx_q, idx_d;
  logic dma_q, dma_d;
  armd_dma_mode_e mode_q, mode_d;
  logic [15:0] rdata_q, rdata_d, ddata_q, ddata_d;
  logic [7:0] status;
  logic [8:0] rem;
  logic consume;
  logic [31:0] nxt;

  // ----------------------------------------
  // address stepping
  // ----------------------------------------
  // packed as {dh, ch, cl, sn}; chs wraps sector, then head, then cylinder
  function automatic logic [31:0] addr_step(input logic lba, input logic [7:0] sn, input logic [7:0] cl,
                                            input logic [7:0] ch, input logic [7:0] dh);
    logic [27:0] l;
    logic [15:0] cyl;
    logic [31:0] r;
    l = {dh[3:0], ch, cl, sn} + 28'h000_0001;
    cyl = {ch, cl} + 16'h0001;
    r = {dh, ch, cl, sn};
    if (lba)
    begin
      r = {dh[7:4], l}; // RQ16 RQ19
    end
    else if (sn != `ARMD_CHS_SPT)
    begin
      r[7:0] = sn + 8'h01;
    end
    else
    begin
      r[7:0] = 8'h01;
      if (dh[3:0] != `ARMD_CHS_HEAD_LAST)
      begin
        r[27:24] = dh[3:0] + 4'h1;
      end
      else
      begin
        r[27:24] = 4'h0;
        r[23:8] = cyl;
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // status and derived values
  // ----------------------------------------
  always_comb
  begin
    status = 8'h00;
    status[`ARMD_ST_BSY] = bsy_q;
    status[`ARMD_ST_DRDY] = ~bsy_q;
    status[`ARMD_ST_DSC] = ~bsy_q;
    status[`ARMD_ST_DRQ] = drq_q;
    status[`ARMD_ST_ERR] = errst_q;
    rem = (sc_q == 8'h00) ? 9'h100 : {1'b0, sc_q}; // RQ3 RQ20
    nxt = addr_step(dh_q[`ARMD_DH_LBA], sn_q, cl_q, ch_q, dh_q);
  end

  // a word leaves only when the transfer phase accepts it
  assign consume = (state_q == DEV_XFER) &&
                   (dma_q ? bus.dmack : (bus.rd_stb && bus.addr == `ARMD_OFS_DATA)); // RQ12

  // ----------------------------------------
  // command sequencer, next values
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    fr_d = fr_q;
    err_d = err_q;
    sc_d = sc_q;
    sn_d = sn_q;
    cl_d = cl_q;
    ch_d = ch_q;
    dh_d = dh_q;
    bsy_d = bsy_q;
    drq_d = drq_q;
    errst_d = errst_q;
    intrq_d = intrq_q;
    mult_d = mult_q;
    blk_d = blk_q;
    idx_d = idx_q;
    dma_d = dma_q;
    mode_d = mode_q;
    rdata_d = rdata_q;
    ddata_d = ddata_q;

    // register reads; a status read acknowledges the interrupt
    if (bus.rd_stb)
    begin
      case (bus.addr)
        `ARMD_OFS_FEAT: rdata_d = {8'h00, err_q};
        `ARMD_OFS_SC: rdata_d = {8'h00, sc_q};
        `ARMD_OFS_SN: rdata_d = {8'h00, sn_q};
        `ARMD_OFS_CL: rdata_d = {8'h00, cl_q};
        `ARMD_OFS_CH: rdata_d = {8'h00, ch_q};
        `ARMD_OFS_DH: rdata_d = {8'h00, dh_q};
        `ARMD_OFS_CMD:
        begin
          rdata_d = {8'h00, status};
          intrq_d = 1'b0;
        end
        default: rdata_d = 16'h0000;
      endcase
    end

    // task-file writes are ignored while a command runs
    if (bus.wr_stb && state_q == DEV_IDLE)
    begin
      case (bus.addr)
        `ARMD_OFS_FEAT: fr_d = bus.wdata;
        `ARMD_OFS_SC: sc_d = bus.wdata;
        `ARMD_OFS_SN: sn_d = bus.wdata;
        `ARMD_OFS_CL: cl_d = bus.wdata;
        `ARMD_OFS_CH: ch_d = bus.wdata;
        `ARMD_OFS_DH: dh_d = bus.wdata;
        `ARMD_OFS_CMD:
        begin
          if (dh_q[`ARMD_DH_DRV] == `ARMD_OWN_DRIVE) // RQ21
          begin
            err_d = 8'h00;
            errst_d = 1'b0;
            blk_d = 8'h00;
            case (bus.wdata)
              `ARMD_CMD_RD_MULT:
              begin
                if (mult_q != 8'h00)
                begin
                  dma_d = 1'b0;
                  bsy_d = 1'b1;
                  state_d = DEV_FETCH;
                end
                else
                begin
                  err_d[`ARMD_ER_ABRT] = 1'b1; // RQ7
                  errst_d = 1'b1;
                  intrq_d = 1'b1;
                end
              end
              `ARMD_CMD_RD_DMA, `ARMD_CMD_RD_DMA_NR:
              begin
                dma_d = 1'b1;
                bsy_d = 1'b1;
                state_d = DEV_FETCH;
              end
              `ARMD_CMD_SET_MULT:
              begin
                mult_d = sc_q; // zero disables multiple mode
                intrq_d = 1'b1;
              end
              `ARMD_CMD_SET_FEAT:
              begin
                intrq_d = 1'b1;
                if (fr_q == `ARMD_FEAT_XFER_MODE && sc_q == `ARMD_MODE_MW2)
                begin
                  mode_d = DMA_MW2; // RQ17
                end
                else if (fr_q == `ARMD_FEAT_XFER_MODE && sc_q == `ARMD_MODE_UDMA2)
                begin
                  mode_d = DMA_UDMA2; // RQ18
                end
                else
                begin
                  err_d[`ARMD_ER_ABRT] = 1'b1;
                  errst_d = 1'b1;
                end
              end
              default:
              begin
                err_d[`ARMD_ER_ABRT] = 1'b1;
                errst_d = 1'b1;
                intrq_d = 1'b1;
              end
            endcase
          end
        end
        default: ;
      endcase
    end

    // sector sequencing; an interrupt set here wins over a status read
    case (state_q)
      DEV_IDLE: ;
      DEV_FETCH:
      begin
        if (med_err)
        begin
          // address stays on the failing sector, count drops it
          err_d[`ARMD_ER_UNC] = 1'b1; // RQ8 RQ15
          errst_d = 1'b1;
          sc_d = sc_q - 8'h01; // RQ8 RQ11
          bsy_d = 1'b0;
          drq_d = 1'b0;
          intrq_d = 1'b1; // RQ15
          state_d = DEV_IDLE;
        end
        else
        begin
          idx_d = 8'h00;
          state_d = DEV_XFER;
          if (!dma_q && blk_q == 8'h00)
          begin
            blk_d = (rem > {1'b0, mult_q}) ? mult_q : rem[7:0]; // RQ4 RQ6
            drq_d = 1'b1; // RQ2
            bsy_d = 1'b0;
            intrq_d = 1'b1; // RQ1 RQ9
          end
        end
      end
      DEV_XFER:
      begin
        if (consume)
        begin
          idx_d = idx_q + 8'h01;
          if (dma_q)
          begin
            ddata_d = med_word;
          end
          else
          begin
            rdata_d = med_word;
          end
          if (idx_q == `ARMD_WORD_LAST)
          begin
            sc_d = sc_q - 8'h01; // RQ11
            blk_d = blk_q - 8'h01;
            if (sc_q == 8'h01)
            begin
              bsy_d = 1'b0;
              drq_d = 1'b0;
              intrq_d = dma_q; // RQ14
              state_d = DEV_IDLE;
            end
            else
            begin
              {dh_d, ch_d, cl_d, sn_d} = nxt; // RQ16
              state_d = DEV_FETCH;
              if (!dma_q && blk_q == 8'h01)
              begin
                drq_d = 1'b0; // RQ2
                bsy_d = 1'b1;
              end
            end
          end
        end
      end
      default: state_d = DEV_IDLE;
    endcase
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q <= DEV_IDLE;
      fr_q <= `ARMD_RST_ZERO;
      err_q <= `ARMD_RST_ERR;
      sc_q <= `ARMD_RST_SC;
      sn_q <= `ARMD_RST_SN;
      cl_q <= `ARMD_RST_ZERO;
      ch_q <= `ARMD_RST_ZERO;
      dh_q <= `ARMD_RST_ZERO;
      bsy_q <= 1'b0;
      drq_q <= 1'b0;
      errst_q <= 1'b0;
      intrq_q <= 1'b0;
      mult_q <= `ARMD_RST_ZERO;
      blk_q <= `ARMD_RST_ZERO;
      idx_q <= `ARMD_RST_ZERO;
      dma_q <= 1'b0;
      mode_q <= DMA_NONE;
      rdata_q <= 16'h0000;
      ddata_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      fr_q <= fr_d;
      err_q <= err_d;
      sc_q <= sc_d;
      sn_q <= sn_d;
      cl_q <= cl_d;
      ch_q <= ch_d;
      dh_q <= dh_d;
      bsy_q <= bsy_d;
      drq_q <= drq_d;
      errst_q <= errst_d;
      intrq_q <= intrq_d;
      mult_q <= mult_d;
      blk_q <= blk_d;
      idx_q <= idx_d;
      dma_q <= dma_d;
      mode_q <= mode_d;
      rdata_q <= rdata_d;
      ddata_q <= ddata_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus.dmarq = (state_q == DEV_XFER) && dma_q; // RQ13
  assign bus.intrq = intrq_q;
  assign bus.rdata = rdata_q;
  assign bus.dma_data = ddata_q;
  assign med_addr = {dh_q[3:0], ch_q, cl_q, sn_q}; // RQ19
  assign med_lba_mode = dh_q[`ARMD_DH_LBA]; // RQ21
  assign med_idx = idx_q;
  assign busy = (state_q != DEV_IDLE);
  assign dma_mode = mode_q;

endmodule

/* hdl/armd_host.sv */
`timescale 1ns/10ps
`include "armd_regs.svh"

module armd_host
  import armd_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  armd_if.host bus,
  input wire logic usr_start,
  input armd_op_e usr_op,
  input wire logic [27:0] usr_lba,
  input wire logic usr_lba_mode,
  input wire logic [7:0] usr_count,
  input wire logic [7:0] usr_arg,
  output logic usr_busy,
  output logic usr_refused,
  output logic usr_done,
  output logic [7:0] usr_status,
  output logic [7:0] usr_error,
  output logic [7:0] usr_end_count,
  output logic [27:0] usr_end_addr,
  output logic [15:0] usr_word,
  output logic usr_word_valid
);

  armd_hst_state_e state_q, state_d;
  armd_op_e op_q, op_d;
  logic [7:0] tf_q [0:6];
  logic [7:0] tf_d [0:6];
  logic [7:0] rb_q [0:6];
  logic [7:0] rb_d [0:6];
  logic [2:0] idx_q, idx_d;
  logic ph_q, ph_d, mset_q, mset_d, ack_q, ack_d, wval_q, wval_d, done_q, done_d, ref_q, ref_d;
  logic [7:0] mult_q, mult_d, blk;
  logic [8:0] rem_q, rem_d;
  logic [15:0] wcnt_q, wcnt_d, word_q, word_d;

  // ----------------------------------------
  // sequencer, next values
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    tf_d = tf_q;
    rb_d = rb_q;
    idx_d = idx_q;
    ph_d = ph_q;
    mset_d = mset_q;
    mult_d = mult_q;
    rem_d = rem_q;
    wcnt_d = wcnt_q;
    word_d = word_q;
    done_d = 1'b0;
    ref_d = 1'b0;
    wval_d = 1'b0;
    ack_d = bus.dmarq && bus.dmack;
    blk = (rem_q > {1'b0, mult_q}) ? mult_q : rem_q[7:0];
    // dma words arrive one cycle after their acknowledge
    if (ack_q)
    begin
      word_d = bus.dma_data;
      wval_d = 1'b1;
    end
    case (state_q)
      HST_IDLE:
      begin
        if (usr_start)
        begin
          if (usr_op == OP_RD_MULT && (usr_count == 8'h00 || !mset_q))
          begin
            ref_d = 1'b1; // RQ5 RQ10
          end
          else
          begin
            op_d = usr_op;
            idx_d = 3'd0;
            state_d = HST_WR;
            rem_d = (usr_count == 8'h00) ? 9'h100 : {1'b0, usr_count};
            tf_d[0] = (usr_op == OP_SET_FEAT) ? `ARMD_FEAT_XFER_MODE : 8'h00; // RQ17 RQ18
            tf_d[1] = (usr_op == OP_SET_MULT || usr_op == OP_SET_FEAT) ? usr_arg : usr_count;
            tf_d[2] = usr_lba[7:0];
            tf_d[3] = usr_lba[15:8];
            tf_d[4] = usr_lba[23:16];
            tf_d[5] = {1'b1, usr_lba_mode, 1'b1, `ARMD_OWN_DRIVE, usr_lba[27:24]};
            case (usr_op)
              OP_RD_MULT: tf_d[6] = `ARMD_CMD_RD_MULT;
              OP_RD_DMA: tf_d[6] = `ARMD_CMD_RD_DMA;
              OP_SET_MULT: tf_d[6] = `ARMD_CMD_SET_MULT;
              default: tf_d[6] = `ARMD_CMD_SET_FEAT;
            endcase
            if (usr_op == OP_SET_MULT)
            begin
              mult_d = usr_arg; // RQ10
              mset_d = (usr_arg != 8'h00);
            end
          end
        end
      end
      HST_WR:
      begin
        idx_d = idx_q + 3'd1;
        if (idx_q == 3'd6)
        begin
          state_d = HST_WAIT;
        end
      end
      HST_WAIT:
      begin
        if (bus.intrq)
        begin
          idx_d = 3'd0;
          ph_d = 1'b0;
          state_d = HST_RDBK;
        end
      end
      HST_RDBK:
      begin
        ph_d = ~ph_q;
        if (ph_q)
        begin
          rb_d[idx_q] = bus.rdata[7:0];
          idx_d = idx_q + 3'd1;
          if (idx_q == 3'd0 && op_q == OP_RD_MULT && bus.rdata[`ARMD_ST_DRQ] && !bus.rdata[`ARMD_ST_ERR])
          begin
            // block start: fetch the whole block without further interrupts
            wcnt_d = {blk, 8'h00};
            rem_d = rem_q - {1'b0, blk};
            state_d = HST_DATA;
          end
          else if (idx_q == 3'd6)
          begin
            done_d = 1'b1;
            state_d = HST_IDLE;
          end
        end
      end
      HST_DATA:
      begin
        ph_d = ~ph_q;
        if (ph_q)
        begin
          word_d = bus.rdata;
          wval_d = 1'b1;
          wcnt_d = wcnt_q - 16'h0001;
          if (wcnt_q == 16'h0001)
          begin
            idx_d = 3'd0;
            state_d = (rem_q == 9'h000) ? HST_RDBK : HST_WAIT;
          end
        end
      end
      default: state_d = HST_IDLE;
    endcase
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q <= HST_IDLE;
      op_q <= OP_RD_MULT;
      for (int i = 0; i < 7; i++)
      begin
        tf_q[i] <= 8'h00;
        rb_q[i] <= 8'h00;
      end
      idx_q <= 3'd0;
      ph_q <= 1'b0;
      mset_q <= 1'b0;
      mult_q <= 8'h00;
      rem_q <= 9'h000;
      wcnt_q <= 16'h0000;
      word_q <= 16'h0000;
      ack_q <= 1'b0;
      wval_q <= 1'b0;
      done_q <= 1'b0;
      ref_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      tf_q <= tf_d;
      rb_q <= rb_d;
      idx_q <= idx_d;
      ph_q <= ph_d;
      mset_q <= mset_d;
      mult_q <= mult_d;
      rem_q <= rem_d;
      wcnt_q <= wcnt_d;
      word_q <= word_d;
      ack_q <= ack_d;
      wval_q <= wval_d;
      done_q <= done_d;
      ref_q <= ref_d;
    end
  end

  // ----------------------------------------
  // bus strobes; reads spaced two cycles so the device can turn a sector
  // ----------------------------------------
  always_comb
  begin
    bus.wr_stb = (state_q == HST_WR);
    bus.wdata = tf_q[idx_q];
    bus.rd_stb = ((state_q == HST_RDBK) || (state_q == HST_DATA)) && !ph_q;
    bus.dmack = (state_q == HST_WAIT) && (op_q == OP_RD_DMA);
    if (state_q == HST_WR)
    begin
      bus.addr = `ARMD_OFS_FEAT + {7'd0, idx_q};
    end
    else if (state_q == HST_DATA || idx_q != 3'd0)
    begin
      bus.addr = `ARMD_OFS_DATA + ((state_q == HST_DATA) ? 10'h000 : {7'd0, idx_q});
    end
    else
    begin
      bus.addr = `ARMD_OFS_CMD;
    end
  end

  assign usr_busy = (state_q != HST_IDLE);
  assign usr_refused = ref_q;
  assign usr_done = done_q;
  assign usr_status = rb_q[0];
  assign usr_error = rb_q[1];
  assign usr_end_count = rb_q[2];
  assign usr_end_addr = {rb_q[6][3:0], rb_q[5], rb_q[4], rb_q[3]};
  assign usr_word = word_q;
  assign usr_word_valid = wval_q;

endmodule

/* hdl/armd_if.sv */
`timescale 1ns/10ps

interface armd_if;
  logic [9:0] addr;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] wdata;
  logic [15:0] rdata;
  logic intrq;
  logic dmarq;
  logic dmack;
  logic [15:0] dma_data;

  modport dev (
    input addr, wr_stb, rd_stb, wdata, dmack,
    output rdata, intrq, dmarq, dma_data
  );

  modport host (
    output addr, wr_stb, rd_stb, wdata, dmack,
    input rdata, intrq, dmarq, dma_data
  );
endinterface

/* hdl/armd_pkg.sv */
package armd_pkg;

  // device sequencer states
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_FETCH = 3'b010,
    DEV_XFER = 3'b100
  } armd_dev_state_e;

  // host sequencer states
  typedef enum logic [4:0] {
    HST_IDLE = 5'b00001,
    HST_WR = 5'b00010,
    HST_WAIT = 5'b00100,
    HST_RDBK = 5'b01000,
    HST_DATA = 5'b10000
  } armd_hst_state_e;

  // user operations of the host end
  typedef enum logic [1:0] {
    OP_RD_MULT = 2'b00,
    OP_RD_DMA = 2'b01,
    OP_SET_MULT = 2'b10,
    OP_SET_FEAT = 2'b11
  } armd_op_e;

  // dma timing mode chosen by set features
  typedef enum logic [1:0] {
    DMA_NONE = 2'b00,
    DMA_MW2 = 2'b01,
    DMA_UDMA2 = 2'b10
  } armd_dma_mode_e;

endpackage

/* hdl/armd_regs.svh */
`ifndef ARMD_REGS_SVH
`define ARMD_REGS_SVH

// ----------------------------------------
// task-file offsets
// ----------------------------------------
`define ARMD_OFS_DATA 10'h1F0
`define ARMD_OFS_FEAT 10'h1F1
`define ARMD_OFS_SC 10'h1F2
`define ARMD_OFS_SN 10'h1F3
`define ARMD_OFS_CL 10'h1F4
`define ARMD_OFS_CH 10'h1F5
`define ARMD_OFS_DH 10'h1F6
`define ARMD_OFS_CMD 10'h1F7

// ----------------------------------------
// command and feature codes
// ----------------------------------------
`define ARMD_CMD_RD_MULT 8'hC4
`define ARMD_CMD_RD_DMA 8'hC8
`define ARMD_CMD_RD_DMA_NR 8'hC9
`define ARMD_CMD_SET_MULT 8'hC6
`define ARMD_CMD_SET_FEAT 8'hEF
`define ARMD_FEAT_XFER_MODE 8'h03
`define ARMD_MODE_MW2 8'h22
`define ARMD_MODE_UDMA2 8'h42

// ----------------------------------------
// field positions
// ----------------------------------------
`define ARMD_ST_BSY 7
`define ARMD_ST_DRDY 6
`define ARMD_ST_DSC 4
`define ARMD_ST_DRQ 3
`define ARMD_ST_ERR 0
`define ARMD_ER_UNC 6
`define ARMD_ER_ABRT 2
`define ARMD_DH_LBA 6
`define ARMD_DH_DRV 4

// ----------------------------------------
// reset values, geometry and counts
// ----------------------------------------
`define ARMD_RST_SC 8'h01
`define ARMD_RST_SN 8'h01
`define ARMD_RST_ERR 8'h01
`define ARMD_RST_ZERO 8'h00
`define ARMD_OWN_DRIVE 1'b0
`define ARMD_WORD_LAST 8'hFF
`define ARMD_CHS_SPT 8'h3F
`define ARMD_CHS_HEAD_LAST 4'hF

`endif

/* verif/armd_properties.sv */
`timescale 1ns/10ps
`include "armd_regs.svh"

module armd_properties (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [9:0] addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  input wire logic intrq,
  input wire logic dmarq,
  input wire logic dmack,
  input wire logic [15:0] dma_data
);
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [8:0] words_q;
  logic [8:0] words_d;
  logic st_rd;
  logic word_move;
  assign st_rd = rd_stb && (addr == `ARMD_OFS_CMD);
  // one dma word is moved in each cycle with request and acknowledge both high
  assign word_move = dmarq && dmack;
  // words of the current burst; one burst must be one whole sector
  always_comb
  begin
    words_d = dmarq ? words_q + {8'h00, dmack} : 9'h000;
  end
  always_ff @(posedge core_clk)
  begin
    words_q <= sys_rst ? 9'h000 : words_d;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_intrq_held: assert property (intrq && !st_rd |=> intrq)
    else $error("intrq dropped without a status read");
  chk_intrq_cleared: assert property (st_rd |=> !intrq)
    else $error("intrq still high after a status read");
  chk_quiet_on_write: assert property (wr_stb |-> !intrq)
    else $error("intrq high during a register write");
  chk_dmarq_no_write: assert property (wr_stb |-> !dmarq)
    else $error("dmarq high during a register write");
  chk_dma_status_once: assert property (dmarq |-> !intrq)
    else $error("intrq high while the dma burst runs");
  chk_dma_data_gate: assert property ($changed(dma_data) |-> $past(word_move))
    else $error("dma data moved without request and acknowledge");
  chk_whole_sector: assert property ($fell(dmarq) |-> words_q == 9'h100)
    else $error("dma burst was not one whole sector");
  chk_rdata_stands: assert property (!$past(rd_stb) |-> $stable(rdata))
    else $error("read data changed without a read");
  cover property ($rose(intrq));
  cover property ($fell(dmarq));
  cover property (st_rd ##1 !intrq);
endmodule

/* verif/tb_top.sv */
`timescale 1ns/10ps
`include "armd_regs.svh"

module tb_top
  import armd_pkg::*;
;
  // ----------------------------------------
  // signals and case table
  // ----------------------------------------
  typedef struct {
    armd_op_e op;
    logic [7:0] cnt;
    logic [7:0] arg;
    logic lm;
    logic [27:0] lba;
    logic [27:0] bad;
    logic [7:0] st;
    logic [7:0] ec;
    logic [27:0] ea;
    int ni;
    int nw;
    armd_dma_mode_e md;
  } armd_row_s;
  localparam logic [27:0] NB = 28'hFFF_FFFF;
  // set ops carry -1 counts; an error mid-block leaves counts open
  armd_row_s rows [10] = '{
    '{OP_SET_MULT, 8'h00, 8'h04, 1'b1, 28'h000_0000, NB, 8'h50, 8'h00, 28'h000_0000, -1, -1, DMA_NONE},
    '{OP_RD_MULT, 8'h09, 8'h00, 1'b1, 28'h000_0FFE, NB, 8'h50, 8'h00, 28'h000_1006, 3, 2304, DMA_NONE},
    '{OP_RD_MULT, 8'h03, 8'h00, 1'b1, 28'h000_0100, NB, 8'h50, 8'h00, 28'h000_0102, 1, 768, DMA_NONE},
    '{OP_RD_MULT, 8'h09, 8'h00, 1'b1, 28'h000_0020, 28'h000_0025, 8'h51, 8'h03, 28'h000_0025, -1, -1, DMA_NONE},
    '{OP_SET_FEAT, 8'h00, 8'h22, 1'b1, 28'h000_0000, NB, 8'h50, 8'h00, 28'h000_0000, -1, -1, DMA_MW2},
    '{OP_RD_DMA, 8'h02, 8'h00, 1'b1, 28'h000_0040, NB, 8'h50, 8'h00, 28'h000_0041, 1, 512, DMA_MW2},
    '{OP_SET_FEAT, 8'h00, 8'h42, 1'b1, 28'h000_0000, NB, 8'h50, 8'h00, 28'h000_0000, -1, -1, DMA_UDMA2},
    '{OP_RD_DMA, 8'h02, 8'h00, 1'b0, 28'h000_053F, NB, 8'h50, 8'h00, 28'h100_0501, 1, 512, DMA_UDMA2},
    '{OP_RD_DMA, 8'h04, 8'h00, 1'b1, 28'h000_0080, 28'h000_0081, 8'h51, 8'h02, 28'h000_0081, 1, 256, DMA_UDMA2},
    '{OP_SET_FEAT, 8'h00, 8'h99, 1'b1, 28'h000_0000, NB, 8'h51, 8'h00, 28'h000_0000, -1, -1, DMA_UDMA2}
  };
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic usr_start = 1'b0;
  armd_op_e usr_op = OP_RD_MULT;
  logic [27:0] usr_lba = 28'h000_0000;
  logic usr_lba_mode = 1'b0;
  logic [7:0] usr_count = 8'h00;
  logic [7:0] usr_arg = 8'h00;
  logic [27:0] bad_addr = NB;
  logic usr_refused;
  logic usr_done;
  logic [7:0] usr_status;
  logic [7:0] usr_error;
  logic [7:0] usr_end_count;
  logic [27:0] usr_end_addr;
  logic usr_word_valid;
  logic [15:0] usr_word;
  logic [27:0] med_addr;
  logic [7:0] med_idx;
  logic [15:0] med_word;
  logic med_err;
  armd_dma_mode_e dma_mode;
  int n_errors = 0;
  int num_checks = 0;
  int n_words = 0;
  int n_ints = 0;
  logic irq_q = 1'b0;
  logic got_ref = 1'b0;

  always #12.5 core_clk = ~core_clk;
  // media answers with a pattern tied to the address; one sector may fail
  assign med_word = {med_addr[7:0], med_idx};
  assign med_err = (med_addr == bad_addr);

  // ----------------------------------------
  // the two ends and the checker
  // ----------------------------------------
  armd_if u_armd_if ();
  armd_device u_armd_device (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .bus(u_armd_if),
    .med_addr(med_addr),
    .med_lba_mode(),
    .med_idx(med_idx),
    .med_word(med_word),
    .med_err(med_err),
    .busy(),
    .dma_mode(dma_mode)
  );
  armd_host u_armd_host (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .bus(u_armd_if),
    .usr_start(usr_start),
    .usr_op(usr_op),
    .usr_lba(usr_lba),
    .usr_lba_mode(usr_lba_mode),
    .usr_count(usr_count),
    .usr_arg(usr_arg),
    .usr_busy(),
    .usr_refused(usr_refused),
    .usr_done(usr_done),
    .usr_status(usr_status),
    .usr_error(usr_error),
    .usr_end_count(usr_end_count),
    .usr_end_addr(usr_end_addr),
    .usr_word(usr_word),
    .usr_word_valid(usr_word_valid)
  );
  armd_properties u_armd_properties (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .addr(u_armd_if.addr),
    .wr_stb(u_armd_if.wr_stb),
    .rd_stb(u_armd_if.rd_stb),
    .rdata(u_armd_if.rdata),
    .intrq(u_armd_if.intrq),
    .dmarq(u_armd_if.dmarq),
    .dmack(u_armd_if.dmack),
    .dma_data(u_armd_if.dma_data)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // words and interrupt rises seen during one command; clean lba reads also check each word's sector and index
  always @(posedge core_clk)
  begin
    if (usr_word_valid === 1'b1)
    begin
      if (bad_addr == NB && usr_lba_mode)
        cmp(usr_word, {usr_lba[7:0] + n_words[15:8], n_words[7:0]});
      n_words++;
    end
    if (u_armd_if.intrq === 1'b1 && irq_q !== 1'b1)
      n_ints++;
    irq_q = u_armd_if.intrq;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // bounded wait, since a lost done pulse must not hang the run
  task automatic run_cmd(input armd_row_s r);
    int k;
    @(posedge core_clk);
    #2;
    usr_op = r.op;
    usr_count = r.cnt;
    usr_arg = r.arg;
    usr_lba_mode = r.lm;
    usr_lba = r.lba;
    bad_addr = r.bad;
    n_words = 0;
    n_ints = 0;
    usr_start = 1'b1;
    @(posedge core_clk);
    #2;
    usr_start = 1'b0;
    k = 0;
    while (usr_done !== 1'b1 && usr_refused !== 1'b1 && k < 70000)
    begin
      @(posedge core_clk);
      #2;
      k++;
    end
    got_ref = usr_refused;
    cmp(k < 70000, 1'b1);
  endtask

  task automatic run_row(input armd_row_s r);
    run_cmd(r);
    cmp(got_ref, 1'b0);
    cmp(usr_status, r.st);
    cmp(dma_mode, r.md);
    if (usr_status[0] === 1'b1)
      cmp(usr_error, r.op == OP_SET_FEAT ? 8'h04 : 8'h40);
    if (r.op == OP_RD_MULT || r.op == OP_RD_DMA)
    begin
      cmp(usr_end_count, r.ec);
      cmp(usr_end_addr, r.ea);
    end
    if (r.ni >= 0)
    begin
      cmp(n_ints, r.ni);
      cmp(n_words, r.nw);
    end
    $display("row ended at %0t", $time);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    armd_row_s r;
    repeat (8) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    foreach (rows[i])
    begin
      run_row(rows[i]);
    end
    // reset again in mid-run: mode returns to none, block size is forgotten
    sys_rst = 1'b1;
    repeat (8) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    cmp(dma_mode, DMA_NONE);
    run_cmd(rows[2]);
    cmp(got_ref, 1'b1);
    run_cmd(rows[0]);
    r = rows[2];
    r.cnt = 8'h00;
    run_cmd(r);
    cmp(got_ref, 1'b1);
    $display("refusal test ended");
    // a count of zero asks for 256 sectors
    run_cmd(rows[6]);
    r = rows[5];
    r.cnt = 8'h00;
    r.lba = 28'h000_0000;
    r.ea = 28'h000_00FF;
    r.nw = 65536;
    r.md = DMA_UDMA2;
    run_row(r);
    complete_run();
  end

  // watchdog; the full run needs about 78k cycles, mostly the 256-sector dma read
  initial
  begin
    repeat (95000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
endmodule
